// file: include/sbcwd_pkg.sv
// sbcwd_pkg: register map, field positions, codes and timing constants
// of the watchdog supervisor.
// assumes: one 100 MHz clock, registers reached by 7-bit address, 8-bit data.

package sbcwd_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_WD_CTRL   = 7'h00;
   localparam logic [6:0] ADDR_MAIN_STAT = 7'h03;
   localparam logic [6:0] ADDR_WD_STATE  = 7'h05;
   localparam logic [6:0] ADDR_CFG       = 7'h74;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int WMC_HI    = 7;
   localparam int WMC_LO    = 5;
   localparam int NWP_HI    = 3;
   localparam int NWP_LO    = 0;
   localparam int CFG_UV_HI = 5;
   localparam int CFG_UV_LO = 4;
   localparam int CFG_FNM   = 3;
   localparam int CFG_SDM   = 2;
   localparam int CFG_SLP   = 0;

   // ---------------------------------------------------------------
   // watchdog mode and period codes
   // ---------------------------------------------------------------
   localparam logic [2:0] WMC_AUTO = 3'h1;
   localparam logic [2:0] WMC_TMO  = 3'h2;
   localparam logic [2:0] WMC_WIN  = 3'h4;

   localparam logic [3:0] NWP_8    = 4'h8;
   localparam logic [3:0] NWP_16   = 4'h1;
   localparam logic [3:0] NWP_32   = 4'h2;
   localparam logic [3:0] NWP_64   = 4'hB;
   localparam logic [3:0] NWP_128  = 4'h4;
   localparam logic [3:0] NWP_256  = 4'hD;
   localparam logic [3:0] NWP_1024 = 4'hE;
   localparam logic [3:0] NWP_4096 = 4'h7;

   // ---------------------------------------------------------------
   // reset values and factory presets
   // ---------------------------------------------------------------
   localparam logic [2:0] WMC_RST     = WMC_TMO;
   localparam logic [2:0] WMC_RST_SDM = WMC_AUTO;
   localparam logic [3:0] NWP_RST     = NWP_128;
   localparam logic [1:0] CFG_UV_RST  = 2'h0;
   localparam logic       CFG_FNM_RST = 1'b1;
   localparam logic       CFG_SDM_RST = 1'b0;
   localparam logic       CFG_SLP_RST = 1'b0;

   // ---------------------------------------------------------------
   // reset causes and system modes
   // ---------------------------------------------------------------
   localparam logic [4:0] RSS_POWER_ON = 5'h00;
   localparam logic [4:0] RSS_WD_SLEEP = 5'h0C;
   localparam logic [4:0] RSS_EARLY    = 5'h0E;
   localparam logic [4:0] RSS_OVF      = 5'h0F;
   localparam logic [4:0] RSS_ILLEGAL  = 5'h10;

   localparam logic [1:0] MODE_NORMAL  = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_SLEEP   = 2'h2;
   localparam logic [1:0] MODE_OTHER   = 2'h3;

   localparam logic [1:0] PHASE_OFF    = 2'h0;
   localparam logic [1:0] PHASE_FIRST  = 2'h1;
   localparam logic [1:0] PHASE_SECOND = 2'h2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int MS_NS     = 1000000;
   localparam int CLK_NS    = 10;
   localparam int MS_CYCLES = MS_NS / CLK_NS;

   typedef enum logic [2:0] {
      WD_OFF = 3'b001,
      WD_WIN = 3'b010,
      WD_TMO = 3'b100
   } sbcwd_eff_e;

   function automatic logic wmc_valid(input logic [2:0] code);
      wmc_valid = (code == WMC_AUTO) || (code == WMC_TMO) ||
                  (code == WMC_WIN);
   endfunction

   // period in ms; zero marks an invalid code
   function automatic logic [12:0] nwp_ms(input logic [3:0] code);
      unique case (code)
         NWP_8:    nwp_ms = 13'h0008;
         NWP_16:   nwp_ms = 13'h0010;
         NWP_32:   nwp_ms = 13'h0020;
         NWP_64:   nwp_ms = 13'h0040;
         NWP_128:  nwp_ms = 13'h0080;
         NWP_256:  nwp_ms = 13'h0100;
         NWP_1024: nwp_ms = 13'h0400;
         NWP_4096: nwp_ms = 13'h1000;
         default:  nwp_ms = 13'h0000;
      endcase
   endfunction

endpackage

// file: core/sbcwd_nvcfg.sv
// sbcwd_nvcfg: persistent chip configuration cells.
// assumes: nv_init_n only pulses when the storage is freshly erased;
// the system reset never touches these cells.
`timescale 1ns/1ps

module sbcwd_nvcfg
   import sbcwd_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nv_init_n,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   output logic [1:0]      startup_uv_threshold,
   output logic            forced_normal_enable,
   output logic            sw_dev_enable,
   output logic            sleep_cmd_block
);

   // ---------------------------------------------------------------
   // storage, kept through system resets
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nv_init_n) begin
         startup_uv_threshold <= CFG_UV_RST;
         forced_normal_enable <= CFG_FNM_RST;
         sw_dev_enable        <= CFG_SDM_RST;
         sleep_cmd_block      <= CFG_SLP_RST;
      end else if (wr) begin
         startup_uv_threshold <= wdata[CFG_UV_HI:CFG_UV_LO];
         forced_normal_enable <= wdata[CFG_FNM];
         sw_dev_enable        <= wdata[CFG_SDM];
         sleep_cmd_block      <= wdata[CFG_SLP];
      end
   end

endmodule

// file: core/sbcwd_timer.sv
// sbcwd_timer: millisecond time base and watchdog period counter.
// assumes: period_ms is never zero while run is high.
`timescale 1ns/1ps

module sbcwd_timer
   import sbcwd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = MS_CYCLES
)(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic        restart,
   input  wire logic [12:0] period_ms,
   output logic             overflow,
   output logic             second_half
);

   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   logic [PW-1:0] pre_cnt;
   logic [12:0]   ms_cnt;
   logic          tick;

   assign tick = (pre_cnt == PRE_LAST);
   assign second_half = (ms_cnt >= (period_ms >> 1));

   // ---------------------------------------------------------------
   // prescaler; restart also realigns the millisecond grid
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst || !run || restart || tick)
         pre_cnt <= '0;
      else
         pre_cnt <= pre_cnt + PW'(1);
   end

   // ---------------------------------------------------------------
   // period counter, wraps on overflow so the watchdog keeps running
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst || !run || restart) begin
         ms_cnt   <= '0;
         overflow <= 1'b0;
      end else if (tick && (ms_cnt + 13'h0001 == period_ms)) begin
         ms_cnt   <= '0;
         overflow <= 1'b1;
      end else begin
         ms_cnt   <= tick ? ms_cnt + 13'h0001 : ms_cnt;
         overflow <= 1'b0;
      end
   end

endmodule

// file: core/sbcwd_top.sv
// sbcwd_top: watchdog supervisor with mode selection, persistent
// configuration and status reporting.
// assumes: sys_mode and wake inputs come from the chip mode controller;
// the reset generator turns sys_reset_req into nrst.
`timescale 1ns/1ps

module sbcwd_top
   import sbcwd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = MS_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       por_n,
   input  wire logic       nv_init_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [1:0] sys_mode,
   input  wire logic       rxd_low_in,
   input  wire logic       wake_event,
   input  wire logic       rxd_release,
   input  wire logic       wd_fail_clr,
   input  wire logic       serial_access_fail_enable,
   output logic [7:0]      reg_rdata,
   output logic            sys_reset_req,
   output logic [4:0]      reset_cause,
   output logic            serial_access_fail,
   output logic            wd_fail_flag,
   output logic            wake_req,
   output logic            go_standby,
   output logic            rxd_force_low,
   output logic            mcu_supply,
   output logic [1:0]      wd_phase,
   output logic            forced_normal_op,
   output logic            sw_dev_op,
   output logic            sleep_cmd_block,
   output logic [1:0]      startup_uv_threshold
);

   logic [2:0]  wd_mode_sel, new_wmc;
   logic [3:0]  wd_period_sel, new_nwp;
   logic [1:0]  uv_cfg, mode_q;
   sbcwd_eff_e  eff, eff_q;
   logic        forced_normal_enable, sw_dev_enable, sleep_blk_cfg;
   logic        wd_ovf, second_half, wr_ctrl, code_ok, changed;
   logic        illegal, trig, early, win_ovf, tmo_ovf, tmo_reset;
   logic        sleep_wd_wake, auto_wake, rxd_low, sleep_entry;

   // ---------------------------------------------------------------
   // persistent configuration and period counter
   // ---------------------------------------------------------------
   sbcwd_nvcfg sbcwd_nvcfg_inst (
      .mclk                 (mclk),
      .nv_init_n            (nv_init_n),
      .wr                   (reg_wr && (reg_addr == ADDR_CFG)),
      .wdata                (reg_wdata),
      .startup_uv_threshold (uv_cfg),
      .forced_normal_enable (forced_normal_enable),
      .sw_dev_enable        (sw_dev_enable),
      .sleep_cmd_block      (sleep_blk_cfg)
   );

   sbcwd_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) sbcwd_timer_inst (
      .mclk        (mclk),
      .nrst        (nrst),
      .run         (eff != WD_OFF),
      .restart     (trig || (eff != eff_q) || auto_wake),
      .period_ms   (nwp_ms(wd_period_sel)),
      .overflow    (wd_ovf),
      .second_half (second_half)
   );

   // ---------------------------------------------------------------
   // control write decode
   // ---------------------------------------------------------------
   assign wr_ctrl = reg_wr && (reg_addr == ADDR_WD_CTRL);
   assign new_wmc = reg_wdata[WMC_HI:WMC_LO];
   assign new_nwp = reg_wdata[NWP_HI:NWP_LO];
   // a single flipped bit never lands on another legal code
   assign code_ok = wmc_valid(new_wmc) &&
                    (nwp_ms(new_nwp) != 13'h0000);
   assign changed = (new_wmc != wd_mode_sel) ||
                    (new_nwp != wd_period_sel);
   assign illegal = wr_ctrl && code_ok && changed &&
                    (sys_mode == MODE_NORMAL);
   assign trig    = wr_ctrl && code_ok && !illegal;

   // ---------------------------------------------------------------
   // effective watchdog behaviour
   // ---------------------------------------------------------------
   assign rxd_low = rxd_force_low || rxd_low_in;

   always_comb begin
      eff = WD_OFF;
      if (!forced_normal_enable) begin
         unique case (wd_mode_sel)
            WMC_WIN: begin
               if (sys_mode == MODE_NORMAL)
                  eff = WD_WIN;
               else if (sys_mode != MODE_OTHER)
                  eff = WD_TMO;
            end
            WMC_TMO: begin
               if (sys_mode != MODE_OTHER)
                  eff = WD_TMO;
            end
            WMC_AUTO: begin
               if (!sw_dev_enable &&
                   ((sys_mode == MODE_NORMAL) ||
                    (sys_mode == MODE_STANDBY && rxd_low)))
                  eff = WD_TMO;
            end
            default: eff = WD_OFF;
         endcase
      end
   end

   assign early     = trig && (eff == WD_WIN) && !second_half;
   assign win_ovf   = wd_ovf && (eff == WD_WIN);
   assign tmo_ovf   = wd_ovf && (eff == WD_TMO);
   assign tmo_reset = tmo_ovf && wd_fail_flag;
   assign sleep_wd_wake = tmo_ovf && !wd_fail_flag &&
                          (sys_mode == MODE_SLEEP);
   assign auto_wake = wake_event && (wd_mode_sel == WMC_AUTO);
   assign sleep_entry = (sys_mode == MODE_SLEEP) &&
                        (mode_q != MODE_SLEEP);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         eff_q  <= WD_OFF;
         mode_q <= MODE_NORMAL;
      end else begin
         eff_q  <= eff;
         mode_q <= sys_mode;
      end
   end

   // ---------------------------------------------------------------
   // watchdog control register
   // ---------------------------------------------------------------
   // the reset value depends on the persistent bit; legal because
   // the reset is synchronous
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wd_mode_sel   <= sw_dev_enable ? WMC_RST_SDM : WMC_RST;
         wd_period_sel <= NWP_RST;
      end else if (trig) begin
         wd_mode_sel   <= new_wmc;
         wd_period_sel <= new_nwp;
      end
   end

   // ---------------------------------------------------------------
   // failure flag; a new overflow beats a software clear
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst)
         wd_fail_flag <= 1'b0;
      else if (tmo_ovf)
         wd_fail_flag <= 1'b1;
      else if (wd_fail_clr)
         wd_fail_flag <= 1'b0;
   end

   // ---------------------------------------------------------------
   // system reset requests and their cause
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst)
         sys_reset_req <= 1'b0;
      else
         sys_reset_req <= illegal || early || win_ovf ||
                          tmo_reset;
   end

   // cause survives the system reset so software can read it after
   always_ff @(posedge mclk) begin
      if (!por_n)
         reset_cause <= RSS_POWER_ON;
      else if (illegal)
         reset_cause <= RSS_ILLEGAL;
      else if (early)
         reset_cause <= RSS_EARLY;
      else if (win_ovf || tmo_reset)
         reset_cause <= RSS_OVF;
      else if (sleep_wd_wake)
         reset_cause <= RSS_WD_SLEEP;
   end

   always_ff @(posedge mclk) begin
      if (!nrst)
         serial_access_fail <= 1'b0;
      else
         serial_access_fail <= serial_access_fail_enable && wr_ctrl &&
                               (!code_ok || illegal);
   end

   // ---------------------------------------------------------------
   // wake-up side effects
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wake_req   <= 1'b0;
         go_standby <= 1'b0;
      end else begin
         wake_req   <= sleep_wd_wake ||
                       (auto_wake && sys_mode == MODE_SLEEP);
         go_standby <= auto_wake && (sys_mode == MODE_SLEEP);
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst)
         rxd_force_low <= 1'b0;
      else if (sleep_wd_wake || auto_wake)
         rxd_force_low <= 1'b1;
      else if (rxd_release)
         rxd_force_low <= 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (!nrst)
         mcu_supply <= 1'b1;
      else if (sleep_wd_wake || (auto_wake && sys_mode == MODE_SLEEP))
         mcu_supply <= 1'b1;
      else if (sleep_entry)
         mcu_supply <= 1'b0;
   end

   // ---------------------------------------------------------------
   // status and read-back
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wd_phase             <= PHASE_OFF;
         forced_normal_op     <= 1'b0;
         sw_dev_op            <= 1'b0;
         sleep_cmd_block      <= 1'b0;
         startup_uv_threshold <= CFG_UV_RST;
      end else begin
         wd_phase <= (eff == WD_OFF) ? PHASE_OFF :
                     (second_half ? PHASE_SECOND : PHASE_FIRST);
         forced_normal_op     <= forced_normal_enable;
         // the forced bit overrules development operation
         sw_dev_op            <= sw_dev_enable &&
                                 !forced_normal_enable;
         sleep_cmd_block      <= sleep_blk_cfg;
         startup_uv_threshold <= uv_cfg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_WD_CTRL:   reg_rdata <= {wd_mode_sel, 1'b0, wd_period_sel};
            ADDR_MAIN_STAT: reg_rdata <= {3'h0, reset_cause};
            ADDR_WD_STATE:  reg_rdata <= {4'h0, forced_normal_op,
                                          sw_dev_op, wd_phase};
            ADDR_CFG:       reg_rdata <= {2'h0, uv_cfg,
                                          forced_normal_enable,
                                          sw_dev_enable, 1'b0,
                                          sleep_blk_cfg};
            default:        reg_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   fnm_off_a: assert property (forced_normal_enable &&
      $past(forced_normal_enable) |-> wd_phase == PHASE_OFF)
      else $error("watchdog active in forced normal");
   phase_code_a: assert property (wd_phase != 2'h3)
      else $error("reserved phase code");
   status_read_a: assert property (reg_rd && reg_addr == ADDR_WD_STATE
      |=> reg_rdata[3:2] == {$past(forced_normal_op), $past(sw_dev_op)})
      else $error("status bits wrong");
   sdm_reload_a: assert property (disable iff (1'b0)
      $rose(nrst) && sw_dev_enable |-> wd_mode_sel == WMC_AUTO)
      else $error("no autonomous mode after reset");
   bad_code_a: assert property (wr_ctrl && !code_ok
      |=> $stable(wd_mode_sel) && $stable(wd_period_sel))
      else $error("invalid code stored");
   illegal_chg_a: assert property (illegal
      |=> sys_reset_req && reset_cause == RSS_ILLEGAL)
      else $error("normal-mode change not punished");
   early_trig_a: assert property (early
      |=> sys_reset_req && reset_cause == RSS_EARLY)
      else $error("early trigger not punished");
   tmo_fail_a: assert property (tmo_ovf && !wd_fail_flag
      |=> wd_fail_flag && !sys_reset_req)
      else $error("overflow did not set failure flag");
   auto_wake_a: assert property (auto_wake |=> rxd_force_low &&
      go_standby == ($past(sys_mode) == MODE_SLEEP))
      else $error("autonomous wake not handled");

   win_ok_c:   cover property (trig && eff == WD_WIN && second_half);
   slp_wake_c: cover property (sleep_wd_wake ##1 wake_req);
   illegal_c:  cover property (illegal);

endmodule

// file: sim/sbcwd_mcu.sv
// sbcwd_mcu: controller model that services watchdog wake-ups.
// assumes: wake_req is a one-cycle pulse from the supervisor.
`timescale 1ns/1ps

module sbcwd_mcu #(
   parameter int LAT = 2
)(
   input  wire logic mclk,
   input  wire logic wake_req,
   output logic      wd_fail_clr
);
   // software is slow to react, so the flag is seen set first
   logic [7:0] sh = 8'h00;
   always_ff @(posedge mclk) begin
      sh <= {sh[6:0], wake_req};
   end
   assign wd_fail_clr = sh[LAT-1];
endmodule

// file: sim/tb_top.sv
// tb_top: register-level tests of the watchdog supervisor.
// assumes: TICK_CYCLES of 10, so 1 ms is 10 clocks.
`timescale 1ns/1ps

module tb_top;
   import sbcwd_pkg::*;
   logic       mclk, nrst, por_n, nv_init_n, reg_wr, reg_rd;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] sys_mode, wd_phase, startup_uv_threshold;
   logic       rxd_low_in, wake_event, rxd_release, wd_fail_clr;
   logic       serial_access_fail_enable, sys_reset_req, serial_access_fail;
   logic       wd_fail_flag, wake_req, go_standby, rxd_force_low;
   logic       mcu_supply, forced_normal_op, sw_dev_op, sleep_cmd_block;
   logic [4:0] reset_cause;
   int         errors, checked, cyc;

   sbcwd_top #(.TICK_CYCLES(10)) sbcwd_top_inst (.mclk, .nrst, .por_n,
      .nv_init_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .sys_mode,
      .rxd_low_in, .wake_event, .rxd_release, .wd_fail_clr, .serial_access_fail_enable,
      .reg_rdata, .sys_reset_req, .reset_cause, .serial_access_fail,
      .wd_fail_flag, .wake_req, .go_standby, .rxd_force_low, .mcu_supply,
      .wd_phase, .forced_normal_op, .sw_dev_op, .sleep_cmd_block,
      .startup_uv_threshold);
   sbcwd_mcu sbcwd_mcu_inst (.mclk, .wake_req, .wd_fail_clr);

   // --------------------
   // access tasks
   // --------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task automatic rs;
      @(posedge mclk);
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // bounded wait on wake, flag or reset request
   task automatic wt(input int k);
      logic [2:0] v;
      for (int i = 0; i < 1500; i++) begin
         cy(1);
         v = {wake_req, wd_fail_flag, sys_reset_req};
         if (v[k] === 1'b1) break;
      end
   endtask
   task results;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 12000) begin
         errors++;
         results;
      end
   end

   // --------------------
   // tests
   // --------------------
   initial begin
      {nrst, por_n, nv_init_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
      {rxd_low_in, wake_event, rxd_release} = 0;
      sys_mode = MODE_STANDBY;
      serial_access_fail_enable = 1;
      repeat (20) @(posedge mclk);
      {nrst, por_n, nv_init_n} <= 3'h7;
      rd(ADDR_CFG, 8'h08);
      rd(ADDR_WD_STATE, 8'h08);
      wr(ADDR_CFG, 8'h11);
      cy(1);
      chk(startup_uv_threshold, 8'h01);
      chk(sleep_cmd_block, 1);
      rd(ADDR_CFG, 8'h11);
      rd(ADDR_WD_STATE, 8'h01);
      wr(ADDR_WD_CTRL, 8'h88);
      rd(ADDR_WD_CTRL, 8'h88);
      wr(ADDR_WD_CTRL, 8'h68);
      chk(serial_access_fail, 1);
      rd(ADDR_WD_CTRL, 8'h88);
      @(posedge mclk);
      sys_mode <= MODE_NORMAL;
      wr(ADDR_WD_CTRL, 8'h88);
      chk(sys_reset_req, 1);
      chk(reset_cause, RSS_EARLY);
      rs;
      sys_mode <= MODE_STANDBY;
      wr(ADDR_WD_CTRL, 8'h88);
      @(posedge mclk);
      sys_mode <= MODE_NORMAL;
      cy(50);
      wr(ADDR_WD_CTRL, 8'h88);
      chk(sys_reset_req, 0);
      wt(0);
      chk(reset_cause, RSS_OVF);
      rs;
      wr(ADDR_WD_CTRL, 8'h88);
      chk(reset_cause, RSS_ILLEGAL);
      rs;
      sys_mode <= MODE_STANDBY;
      wr(ADDR_WD_CTRL, 8'h48);
      wt(1);
      chk(sys_reset_req, 0);
      wt(0);
      chk(reset_cause, RSS_OVF);
      rs;
      sys_mode <= MODE_SLEEP;
      wt(2);
      chk({rxd_force_low, mcu_supply, wd_fail_flag}, 8'h07);
      chk(reset_cause, RSS_WD_SLEEP);
      cy(4);
      chk(wd_fail_flag, 0);
      @(posedge mclk);
      sys_mode <= MODE_STANDBY;
      rxd_release <= 1;
      @(posedge mclk);
      rxd_release <= 0;
      wr(ADDR_WD_CTRL, 8'h28);
      rd(ADDR_WD_STATE, 8'h00);
      @(posedge mclk);
      wake_event <= 1;
      @(posedge mclk);
      wake_event <= 0;
      #1;
      chk(rxd_force_low, 1);
      rd(ADDR_WD_STATE, 8'h01);
      // autonomous wake while sleeping must also leave sleep
      @(posedge mclk);
      sys_mode <= MODE_SLEEP;
      wake_event <= 1;
      @(posedge mclk);
      wake_event <= 0;
      #1;
      chk({wake_req, go_standby, mcu_supply}, 8'h07);
      wr(ADDR_CFG, 8'h04);
      rs;
      rd(ADDR_WD_CTRL, 8'h24);
      rd(ADDR_WD_STATE, 8'h04);
      results;
   end
endmodule
